/* File: verilog/panel_output_port.sv */
// panel output port: pixel fifo, formatting, polarity and pin control
// assumes clk at 125 MHz, link_clk far slower (at most clk/4) and
// unrelated; the pad ring turns each oe into a tri-state driver
//
// Overview of operation
// - pair bit clear: one 24-bit pixel per pixel output clock
// - pair bit set: two pixels, one per channel, every second clock
// - reduced depth: keep upper six bits per colour, low two zero
// - composite sync bit: vertical sync pin carries combined sync
// - clock disable: both output clock pins high impedance
// - data disable: syncs, data enable, both channels high impedance
// - pixel clock invert moves alignment from rising to falling edge
// - half-rate clock invert moves alignment from rising to falling edge
// - data enable active high, inverted when its invert bit set
// - horizontal sync active high, inverted when its invert bit set
// - vertical sync active high, inverted when its invert bit set
// - half-rate phase bit advances half-rate clock by half pixel period
// - pixel clock phase codes 00,10,01,11 give ever earlier edges
// - run enable clear clamps every pin low, over all inversions; clk_oe and ctl_oe still follow their disable bits
//
// Strobed register access was decided locally.
`include "panel_params.svh"
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// pixel fifo
// ****************************************************************
module panel_fifo #(
    parameter int WIDTH = 27,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    if (WIDTH < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("fifo needs a width of one or more and a power-of-two depth of two or more");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    assign in_ready = (count_q != (AW+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign out_data = mem_q[rd_ptr_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

endmodule : panel_fifo

// ****************************************************************
// output port
// ****************************************************************
module panel_output_port
    import panel_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic link_clk,
    input wire logic in_valid,
    output logic in_ready,
    input wire stream_word_t in_word,
    output panel_pins_t pins,
    output logic clk_oe,
    output logic ctl_oe
);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic rgb_t cut_depth(input rgb_t p, input logic cut);
        rgb_t r;
        r = p;
        if (cut) begin
            r.red = p.red & `DEPTH_MASK;
            r.green = p.green & `DEPTH_MASK;
            r.blue = p.blue & `DEPTH_MASK;
        end
        return r;
    endfunction : cut_depth

    function automatic logic low_bits(input rgb_t p);
        return |{p.red[1:0], p.green[1:0], p.blue[1:0]};
    endfunction : low_bits

    // ************************************************************
    // registers
    // ************************************************************
    logic [9:0] fmt_q;
    logic [2:0] phase_q;
    logic run_q;
    logic [31:0] rdata_q;
    logic [2:0] cfg_age_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fmt_q <= `RST_FORMAT;
            phase_q <= `RST_PHASE;
            run_q <= `RST_RUN;
        end else if (reg_wr) begin
            if (reg_addr == `ADDR_FORMAT) begin
                fmt_q <= reg_wdata[9:0];
            end
            if (reg_addr == `ADDR_PHASE) begin
                phase_q <= reg_wdata[2:0];
            end
            if (reg_addr == `ADDR_RUN_CTRL) begin
                run_q <= reg_wdata[`F_RUN];
            end
        end
    end

    // read data stands one cycle only; unmapped reads give zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= '0;
        end else if (!reg_rd) begin
            rdata_q <= '0;
        end else if (reg_addr == `ADDR_FORMAT) begin
            rdata_q <= {22'h0, fmt_q};
        end else if (reg_addr == `ADDR_PHASE) begin
            rdata_q <= {29'h0, phase_q};
        end else if (reg_addr == `ADDR_RUN_CTRL) begin
            rdata_q <= {30'h0, run_q, 1'b0};
        end else begin
            rdata_q <= '0;
        end
    end

    assign reg_rdata = rdata_q;

    // cycles since the last register write, saturating
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_age_q <= '0;
        end else if (reg_wr) begin
            cfg_age_q <= '0;
        end else if (cfg_age_q != 3'h7) begin
            cfg_age_q <= cfg_age_q + 3'h1;
        end
    end

    // ************************************************************
    // link clock sampling
    // ************************************************************
    logic [1:0] lsync_q;
    logic [2:0] lhist_q;
    logic rise;
    logic fall;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lsync_q <= '0;
            lhist_q <= '0;
        end else begin
            lsync_q <= {lsync_q[0], link_clk};
            lhist_q <= {lhist_q[1:0], lsync_q[1]};
        end
    end

    assign rise = lsync_q[1] && !lhist_q[0];
    assign fall = !lsync_q[1] && lhist_q[0];

    // ************************************************************
    // pixel fifo, drained one word per link clock rise
    // ************************************************************
    stream_word_t f_word;
    stream_word_t cur;
    logic f_valid;

    panel_fifo #(
        .WIDTH($bits(stream_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rstn(rstn),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data(in_word),
        .out_valid(f_valid),
        .out_ready(rise),
        .out_data(f_word)
    );

    // an empty fifo yields a blank, inactive word rather than stalling
    assign cur = f_valid ? f_word : '0;

    // ************************************************************
    // half-rate clock
    // ************************************************************
    logic hr_q;
    logic hr_early_q;
    logic [1:0] hr_hist_q;
    logic [1:0] hre_hist_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hr_q <= 1'b0;
            hr_early_q <= 1'b0;
        end else begin
            if (rise) begin
                hr_q <= !hr_q;
            end
            if (fall) begin
                hr_early_q <= !hr_q;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hr_hist_q <= '0;
            hre_hist_q <= '0;
        end else begin
            hr_hist_q <= {hr_hist_q[0], hr_q};
            hre_hist_q <= {hre_hist_q[0], hr_early_q};
        end
    end

    // ************************************************************
    // transfer stage and delay line
    // ************************************************************
    stream_word_t hold_q;
    out_word_t st_q;
    out_word_t dly_q [2];

    // pair mode: first word held, pair sent as half-rate clock rises
    // either half live keeps de up, so an off-phase start keeps its pixel
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hold_q <= '0;
            st_q <= '0;
        end else if (rise) begin
            if (!fmt_q[`F_PAIR]) begin
                st_q <= '{de: cur.de, hs: cur.hs, vs: cur.vs,
                          a: cur.px, b: '0};
            end else if (hr_q) begin
                hold_q <= cur;
            end else begin
                st_q <= '{de: hold_q.de | cur.de, hs: hold_q.hs, vs: hold_q.vs,
                          a: hold_q.px, b: cur.px};
            end
        end
    end

    // delay leaves room for the clock taps to run ahead of the data
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dly_q[0] <= '0;
            dly_q[1] <= '0;
        end else begin
            dly_q[0] <= st_q;
            dly_q[1] <= dly_q[0];
        end
    end

    // ************************************************************
    // pins
    // ************************************************************
    logic pclk_tap;
    panel_pins_t pins_q;
    logic clk_oe_q;
    logic ctl_oe_q;
    out_word_t last;

    assign last = dly_q[1];

    // earlier codes take younger samples of the link clock
    always_comb begin
        unique case (phase_q[`F_PC_PHASE_HI:`F_PC_PHASE_LO])
            2'b00: pclk_tap = lhist_q[2];
            2'b10: pclk_tap = lhist_q[1];
            2'b01: pclk_tap = lhist_q[0];
            2'b11: pclk_tap = lsync_q[1];
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pins_q <= '0;
        end else if (!run_q) begin
            pins_q <= '0;
        end else begin
            pins_q.pixel_output_clock <= pclk_tap ^ fmt_q[`F_PCLK_INV];
            pins_q.half_rate_output_clock <= (phase_q[`F_HR_PHASE] ?
                hre_hist_q[1] : hr_hist_q[1]) ^ fmt_q[`F_HCLK_INV];
            pins_q.data_enable_out <= last.de ^ fmt_q[`F_DE_INV];
            pins_q.horiz_sync_out <= last.hs ^ fmt_q[`F_HS_INV];
            pins_q.vert_sync_out <= (fmt_q[`F_CSYNC] ? (last.hs | last.vs) :
                last.vs) ^ fmt_q[`F_VS_INV];
            pins_q.chan_a <= cut_depth(last.a, fmt_q[`F_REDUCED]);
            pins_q.chan_b <= cut_depth(last.b, fmt_q[`F_REDUCED]);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            clk_oe_q <= 1'b1;
            ctl_oe_q <= 1'b1;
        end else begin
            clk_oe_q <= !fmt_q[`F_CLK_OD];
            ctl_oe_q <= !fmt_q[`F_DATA_OD];
        end
    end

    assign pins = pins_q;
    assign clk_oe = clk_oe_q;
    assign ctl_oe = ctl_oe_q;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_quiet;
        cfg_age_q == 3'h7 && run_q;
    endsequence

    sequence s_ref_rise;
        rise && phase_q[2:1] == 2'b00;
    endsequence

    sequence s_early_rise;
        rise && phase_q[2:1] == 2'b11 && !fmt_q[`F_PCLK_INV];
    endsequence

    single_pixel_a: assert property (
        rise && !fmt_q[`F_PAIR] && f_valid |=> st_q.a == $past(f_word.px))
        else $error("single pixel not taken on link clock rise");

    pair_hold_a: assert property (
        rise && fmt_q[`F_PAIR] && hr_q |=> $stable(st_q))
        else $error("pair transfer changed on first word");

    pair_send_a: assert property (
        rise && fmt_q[`F_PAIR] && !hr_q |=> st_q.a == $past(hold_q.px)
            && st_q.b == $past(cur.px))
        else $error("pair transfer does not carry both pixels");

    depth_cut_a: assert property (
        run_q && fmt_q[`F_REDUCED] |=>
            !low_bits(pins_q.chan_a) && !low_bits(pins_q.chan_b))
        else $error("low colour bits not cleared");

    csync_pin_a: assert property (
        run_q && fmt_q[`F_CSYNC] |=> pins_q.vert_sync_out ==
            $past((last.hs | last.vs) ^ fmt_q[`F_VS_INV]))
        else $error("composite sync wrong on vertical pin");

    clk_float_a: assert property (
        ##1 clk_oe == !$past(fmt_q[`F_CLK_OD]))
        else $error("clock enable does not follow disable bit");

    data_float_a: assert property (
        ##1 ctl_oe == !$past(fmt_q[`F_DATA_OD]))
        else $error("data enable does not follow disable bit");

    pclk_ref_a: assert property (
        s_quiet ##0 s_ref_rise ##0 !fmt_q[`F_PCLK_INV] |->
            ##4 $rose(pins_q.pixel_output_clock))
        else $error("pixel clock not rising with data");

    pclk_inv_a: assert property (
        s_quiet ##0 s_ref_rise ##0 fmt_q[`F_PCLK_INV] |->
            ##4 $fell(pins_q.pixel_output_clock))
        else $error("inverted pixel clock not falling with data");

    hclk_ref_a: assert property (
        s_quiet ##0 rise ##0 !phase_q[`F_HR_PHASE] |-> ##4
            pins_q.half_rate_output_clock == ($past(hr_q, 3) ^ fmt_q[`F_HCLK_INV]))
        else $error("half-rate clock misaligned");

    de_level_a: assert property (
        run_q |=> pins_q.data_enable_out ==
            $past(last.de ^ fmt_q[`F_DE_INV]))
        else $error("data enable polarity wrong");

    hs_path_a: assert property (
        s_quiet ##0 rise |-> ##4
            pins_q.horiz_sync_out == ($past(st_q.hs, 3) ^ fmt_q[`F_HS_INV]))
        else $error("horizontal sync wrong on pin");

    vs_level_a: assert property (
        run_q && !fmt_q[`F_CSYNC] |=> pins_q.vert_sync_out ==
            $past(last.vs ^ fmt_q[`F_VS_INV]))
        else $error("vertical sync polarity wrong");

    hclk_early_a: assert property (
        s_quiet ##0 fall ##0 phase_q[`F_HR_PHASE] |-> ##4
            pins_q.half_rate_output_clock ==
            ($past(hr_early_q, 3) ^ fmt_q[`F_HCLK_INV]))
        else $error("advanced half-rate clock misaligned");

    pclk_early_a: assert property (
        s_quiet ##0 s_early_rise |-> ##1 $rose(pins_q.pixel_output_clock))
        else $error("earliest phase code not earliest");

    clamp_low_a: assert property (
        !run_q |=> pins_q == '0)
        else $error("outputs not clamped low");

    half_rate_a: assert property (
        rise |=> hr_q != $past(hr_q))
        else $error("half-rate clock missed a toggle");

endmodule : panel_output_port

`default_nettype wire

/* File: verilog/panel_params.svh */
// panel output port: register map, field positions, reset values
// assumes a byte-addressed register port, one 32-bit word per register
`ifndef PANEL_PARAMS_SVH
`define PANEL_PARAMS_SVH

// register indices; byte address is four times the index
`define IDX_RUN_CTRL 8'h03
`define IDX_FORMAT 8'h04
`define IDX_PHASE 8'h05
`define ADDR_RUN_CTRL (`IDX_RUN_CTRL << 2)
`define ADDR_FORMAT (`IDX_FORMAT << 2)
`define ADDR_PHASE (`IDX_PHASE << 2)

// format register fields
`define F_PAIR 0
`define F_REDUCED 1
`define F_CSYNC 2
`define F_CLK_OD 3
`define F_DATA_OD 4
`define F_PCLK_INV 5
`define F_HCLK_INV 6
`define F_DE_INV 7
`define F_HS_INV 8
`define F_VS_INV 9
// phase register fields
`define F_HR_PHASE 0
`define F_PC_PHASE_HI 2
`define F_PC_PHASE_LO 1
// run control field
`define F_RUN 1

`define RST_FORMAT 10'h000
`define RST_PHASE 3'h0
`define RST_RUN 1'b0
`define DEPTH_MASK 8'hFC
// cycles from a link clock rise to the pins at reference phase
`define PIN_LATENCY 4

`endif

/* File: verilog/panel_pkg.sv */
// panel output port: types shared by the design
// assumes panel_params.svh supplies the numeric constants
package panel_pkg;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } rgb_t;

    // one pixel with its timing, as written into the port
    typedef struct packed {
        logic de;
        logic hs;
        logic vs;
        rgb_t px;
    } stream_word_t;

    // one transfer on the pins, both channels
    typedef struct packed {
        logic de;
        logic hs;
        logic vs;
        rgb_t a;
        rgb_t b;
    } out_word_t;

    typedef struct packed {
        logic pixel_output_clock;
        logic half_rate_output_clock;
        logic horiz_sync_out;
        logic vert_sync_out;
        logic data_enable_out;
        rgb_t chan_a;
        rgb_t chan_b;
    } panel_pins_t;

endpackage : panel_pkg

/* File: verification/panel_model.sv */
// panel model: the display that samples the port pins
// assumes pins registered on clk and a known clock-to-data lead in clk cycles
`timescale 1ns/1ns
`default_nettype none

// ****************************
// panel sampler
// ****************************
module panel_model
    import panel_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire panel_pins_t pins,
    input wire logic ctl_oe,
    input wire logic pclk_inv,
    input wire logic [1:0] lead,
    output logic got,
    output out_word_t word
);
    logic p_q;
    logic [2:0] sh_q;
    out_word_t last_q;
    out_word_t seen;
    logic edge_now;

    // a released bus floats, so show the inverse of the last level seen
    assign seen = ctl_oe ? {pins.data_enable_out, pins.horiz_sync_out, pins.vert_sync_out,
                            pins.chan_a, pins.chan_b} : ~last_q;
    assign edge_now = (pins.pixel_output_clock != pclk_inv) && (p_q == pclk_inv);

    // data trails the active clock edge by lead cycles
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            p_q <= 1'b0;
            sh_q <= 3'h0;
            got <= 1'b0;
            word <= '0;
            last_q <= '0;
        end else begin
            p_q <= pins.pixel_output_clock;
            sh_q <= {sh_q[1:0], edge_now};
            got <= (lead == 2'h0) ? edge_now : sh_q[lead - 2'h1];
            word <= seen;
            if (ctl_oe) begin
                last_q <= seen;
            end
        end
    end
endmodule : panel_model

`default_nettype wire

/* File: verification/panel_output_port_tb.sv */
// testbench: registers, pin enables, clamp, polarity, single and pair streams
// assumes panel_params.svh addresses and the panel model beside the port
`include "panel_params.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end

module display_output_port_control_tb import panel_pkg::*; ;
    logic clk, rstn, reg_wr, reg_rd, link_clk, link_run, in_valid, in_ready;
    logic clk_oe, ctl_oe, got, mon_en, pc_p, hr_p;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rs;
    logic [9:0] fmt;
    logic [2:0] ph;
    logic [23:0] a_p;
    stream_word_t in_word;
    panel_pins_t pins;
    out_word_t word;
    int err_count, comparisons, cyc, pc_t, hr_t, pc_n, hr_n;
    stream_word_t expq[$];
    out_word_t rxq[$];

    // ****************************
    // clocks and instances
    // ****************************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // link stops low between streams so the fifo can be filled
    initial begin
        link_clk = 1'b0;
        #3;
        forever begin
            #32;
            if (link_run || link_clk) link_clk = ~link_clk;
        end
    end

    panel_output_port #(.FIFO_DEPTH(16)) dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .link_clk(link_clk), .in_valid(in_valid), .in_ready(in_ready), .in_word(in_word),
        .pins(pins), .clk_oe(clk_oe), .ctl_oe(ctl_oe));
    panel_model panel (.clk(clk), .rstn(rstn), .pins(pins), .ctl_oe(ctl_oe),
        .pclk_inv(fmt[`F_PCLK_INV]), .lead({ph[1], ph[2]}), .got(got), .word(word));

    // ****************************
    // monitors
    // ****************************
    always @(posedge clk) begin
        if (got && (word.de ^ fmt[`F_DE_INV])) rxq.push_back(word);
    end
    always @(posedge clk) begin
        cyc++;
        if (pins.pixel_output_clock !== pc_p && pins.pixel_output_clock !== fmt[`F_PCLK_INV]) begin
            pc_t = cyc;
            pc_n++;
        end
        if (pins.half_rate_output_clock !== hr_p) begin
            hr_t = cyc;
            hr_n++;
        end
        if (mon_en && pins.chan_a !== a_p) begin
            `CHK(cyc - pc_t, int'({ph[1], ph[2]}))
            // the advanced half-rate edge has no fall before a stream's first pixel
            if (fmt[`F_PAIR])
                `CHK(pins.half_rate_output_clock, ~fmt[`F_HCLK_INV])
            else if (pc_n > 1) `CHK(cyc - hr_t, ph[`F_HR_PHASE] ? 4 : 0)
        end
        pc_p = pins.pixel_output_clock;
        hr_p = pins.half_rate_output_clock;
        a_p = pins.chan_a;
    end

    // ****************************
    // helpers
    // ****************************
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction : rnd

    function automatic out_word_t expect_px(stream_word_t w);
        out_word_t o;
        o = '0;
        o.de = w.de ^ fmt[`F_DE_INV];
        o.hs = w.hs ^ fmt[`F_HS_INV];
        o.vs = (fmt[`F_CSYNC] ? (w.hs | w.vs) : w.vs) ^ fmt[`F_VS_INV];
        o.a = fmt[`F_REDUCED] ? (w.px & {3{8'hFC}}) : w.px;
        return o;
    endfunction : expect_px

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 `CHK(reg_rdata, e)
        @(posedge clk);
        #1 `CHK(reg_rdata, 32'h0)
        @(posedge clk);
    endtask : rd_chk

    // fill with the link stopped until refused, then drain to the panel
    task automatic stream(input logic [9:0] f, input logic [2:0] p);
        stream_word_t w;
        out_word_t x;
        logic [31:0] r;
        logic [23:0] v;
        int n;
        int k;
        int run;
        link_run = 1'b0;
        repeat (20) @(posedge clk);
        wr(`ADDR_FORMAT, {22'h0, f});
        wr(`ADDR_PHASE, {29'h0, p});
        fmt = f;
        ph = p;
        expq.delete();
        rxq.delete();
        n = 0;
        in_valid <= 1'b1;
        forever begin
            r = rnd();
            w = {1'b1, r[24], r[25], r[23:0] | 24'h000004};
            in_word <= w;
            @(negedge clk);
            if (!in_ready || n > 40) break;
            expq.push_back(w);
            n++;
            @(posedge clk);
        end
        repeat (3) @(posedge clk);
        `CHK(in_ready, 1'b0)
        `CHK(n, 16)
        in_valid <= 1'b0;
        pc_n = 0;
        hr_n = 0;
        mon_en = 1'b1;
        link_run = 1'b1;
        k = 0;
        while (rxq.size() < 16 && k < 1000) begin
            @(posedge clk);
            k++;
        end
        repeat (24) @(posedge clk);
        mon_en = 1'b0;
        `CHK(((pc_n - hr_n) inside {-1, 0, 1}), 1'b1)
        if (!f[`F_PAIR]) begin
            `CHK(rxq.size(), 16)
            foreach (expq[i])
                `CHK(rxq[i], expect_px(expq[i]))
        end else begin
            run = -100;
            foreach (rxq[i]) begin
                if (i > 0 && rxq[i] !== rxq[i - 1]) begin
                    if (run > 0) `CHK(run, 2)
                    run = 0;
                end
                run++;
                for (k = 0; k < 2; k++) begin
                    v = k ? rxq[i].b : rxq[i].a;
                    if (expq.size() > 0) x = expect_px(expq[0]);
                    if (expq.size() > 0 && v === x.a) void'(expq.pop_front());
                end
            end
            `CHK(expq.size(), 0)
        end
    endtask : stream

    task automatic print_verdict();
        if (err_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    // ****************************
    // sequence
    // ****************************
    initial begin
        #500000;
        err_count++;
        print_verdict();
    end

    initial begin
        logic [7:0] adr [4];
        logic [31:0] msk [4];
        logic [31:0] d;
        adr = '{`ADDR_RUN_CTRL, `ADDR_FORMAT, `ADDR_PHASE, 8'h18};
        msk = '{32'h2, 32'h3FF, 32'h7, 32'h0};
        rstn = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        in_valid = 1'b0;
        in_word = '0;
        // link stays still until a stream is queued, so no edge meets a write
        link_run = 1'b0;
        fmt = 10'h000;
        ph = 3'h0;
        mon_en = 1'b0;
        rs = 32'h0000004E;
        err_count = 0;
        comparisons = 0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1 `CHK(pins, '0)
        @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            rd_chk(adr[i], 32'h0);
            d = rnd();
            wr(adr[i], d);
            rd_chk(adr[i], d & msk[i]);
        end
        for (int i = 0; i < 4; i++) begin
            wr(`ADDR_FORMAT, i << 3);
            #1 `CHK({clk_oe, ctl_oe}, ~{i[0], i[1]})
            @(posedge clk);
        end
        wr(`ADDR_RUN_CTRL, 32'h2);
        wr(`ADDR_FORMAT, 32'h3E0);
        // with the link still, the all-zero transfer word left by reset shows the idle polarity
        repeat (40) @(posedge clk);
        #1 `CHK({pins.data_enable_out, pins.horiz_sync_out, pins.vert_sync_out}, 3'h7)
        // above
        @(posedge clk);
        wr(`ADDR_RUN_CTRL, 32'h0);
        repeat (16) begin
            #1 `CHK(pins, '0)
            @(posedge clk);
        end
        wr(`ADDR_RUN_CTRL, 32'h2);
        for (int i = 0; i < 6; i++) begin
            d = rnd();
            // every pixel phase code, both clock inversions, both half-rate phases
            stream((d[9:0] & 10'h386) | {3'h0, i[0], (i > 3), 4'h0, (i > 3)},
                {i[1:0], i[1] ^ i[0]});
        end
        print_verdict();
    end
endmodule : display_output_port_control_tb

`default_nettype wire
